//--- rtl/dac_host_pkg.sv
// constants for the parallel dac write port host controller
package dac_host_pkg;
    localparam int          ADDR_W       = 3;
    localparam int          DATA_W       = 10;
    localparam int          UPPER_W      = 8;
    localparam int          LOWER_W      = 2;
    localparam int          CLK_MHZ      = 20;
    // strobe phase times in ns, each least times, rounded up to cycles
    localparam int          SETUP_NS     = 50;
    localparam int          STROBE_NS    = 100;
    localparam int          HOLD_NS      = 50;
    localparam int          SETUP_CYC    = (SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int          STROBE_CYC   = (STROBE_NS * CLK_MHZ + 999) / 1000;
    localparam int          HOLD_CYC     = (HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam int          CNT_W        = 4;
    localparam logic        CLASS_DATA   = 1'b1;
    localparam logic        CLASS_CTRL   = 1'b0;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_SETUP  = 3'b001,
        ST_STROBE = 3'b010,
        ST_HOLD   = 3'b011,
        ST_UPDATE = 3'b100
    } state_t;
endpackage

//--- rtl/dac_write_host.sv
// host-side controller that drives the parallel dac write port pins
// Contract
// - update low at write edge auto-updates
// - host drives write strobe with select, address
// - chip select active low during writes
// - class select high data, low control
module dac_write_host
    import dac_host_pkg::*;
(
    input  wire logic               i_clk,
    input  wire logic               i_rst,
    input  wire logic               i_req,
    input  wire logic [ADDR_W-1:0]  i_addr,
    input  wire logic               i_class,
    input  wire logic               i_sys,
    input  wire logic [DATA_W-1:0]  i_data,
    input  wire logic               i_auto,
    input  wire logic               i_update,
    input  wire logic               i_clear,
    input  wire logic               i_sleep,
    output logic                    o_busy,
    output logic                    o_done,
    output logic                    o_cs_n,
    output logic                    o_wr_n,
    output logic [ADDR_W-1:0]       o_channel_address,
    output logic                    o_mode,
    output logic [UPPER_W-1:0]      o_data_upper_bits,
    output logic [LOWER_W-1:0]      o_data_lower_bits,
    output logic                    o_output_update_strobe_n,
    output logic                    o_async_output_clear_n,
    output logic                    o_power_down_n
);
    state_t            st_q, st_d;
    logic [CNT_W-1:0]  cnt_q, cnt_d;
    logic              cs_n_q, cs_n_d, wr_n_q, wr_n_d, ld_n_q, ld_n_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic              mode_q, mode_d, done_q, done_d, busy_q, busy_d;
    logic [DATA_W-1:0] data_q, data_d;
    logic              clr_n_q, clr_n_d, pd_n_q, pd_n_d;

    // write sequencer: setup, strobe low, hold, optional update pulse
    always_comb begin
        st_d   = st_q;
        cnt_d  = cnt_q;
        cs_n_d = cs_n_q;
        wr_n_d = wr_n_q;
        ld_n_d = ld_n_q;
        addr_d = addr_q;
        mode_d = mode_q;
        data_d = data_q;
        done_d = 1'b0;
        busy_d = busy_q;
        case (st_q)
            ST_IDLE: begin
                ld_n_d = 1'b1;
                if (i_update) begin
                    ld_n_d = 1'b0;
                    cnt_d  = CNT_W'(STROBE_CYC - 1);
                    busy_d = 1'b1;
                    st_d   = ST_UPDATE;
                end else if (i_req) begin
                    // system control writes park the address at zero: it is ignored anyway
                    addr_d = (i_sys && i_class == CLASS_CTRL) ? '0 : i_addr;
                    mode_d = i_class;
                    data_d = i_data;
                    cs_n_d = 1'b0;
                    ld_n_d = ~i_auto;
                    cnt_d  = CNT_W'(SETUP_CYC - 1);
                    busy_d = 1'b1;
                    st_d   = ST_SETUP;
                end
            end
            ST_SETUP: begin
                if (cnt_q == '0) begin
                    wr_n_d = 1'b0;
                    cnt_d  = CNT_W'(STROBE_CYC - 1);
                    st_d   = ST_STROBE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            ST_STROBE: begin
                if (cnt_q == '0) begin
                    wr_n_d = 1'b1; // rising edge latches, lines still stable
                    cnt_d  = CNT_W'(HOLD_CYC - 1);
                    st_d   = ST_HOLD;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            ST_HOLD: begin
                if (cnt_q == '0) begin
                    cs_n_d = 1'b1;
                    ld_n_d = 1'b1;
                    done_d = 1'b1;
                    busy_d = 1'b0;
                    st_d   = ST_IDLE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            ST_UPDATE: begin
                if (cnt_q == '0) begin
                    ld_n_d = 1'b1;
                    done_d = 1'b1;
                    busy_d = 1'b0;
                    st_d   = ST_IDLE;
                end else begin
                    cnt_d = cnt_q - 1'b1;
                end
            end
            default: begin
                st_d   = ST_IDLE;
                cs_n_d = 1'b1;
                wr_n_d = 1'b1;
                ld_n_d = 1'b1;
                busy_d = 1'b0;
            end
        endcase
    end

    // sequencer registers; pins idle inactive high out of reset
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            st_q   <= ST_IDLE;
            cnt_q  <= '0;
            cs_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            ld_n_q <= 1'b1;
            addr_q <= '0;
            mode_q <= CLASS_CTRL;
            data_q <= '0;
            done_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            cs_n_q <= cs_n_d;
            wr_n_q <= wr_n_d;
            ld_n_q <= ld_n_d;
            addr_q <= addr_d;
            mode_q <= mode_d;
            data_q <= data_d;
            done_q <= done_d;
            busy_q <= busy_d;
        end
    end

    // clear and sleep next values: request levels inverted onto the active-low pins
    always_comb begin
        clr_n_d = ~i_clear;
        pd_n_d  = ~i_sleep;
    end

    // clear and sleep are plain levels, registered so the pins come from flops
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            clr_n_q <= 1'b1;
            pd_n_q  <= 1'b1;
        end else begin
            clr_n_q <= clr_n_d;
            pd_n_q  <= pd_n_d;
        end
    end

    assign o_busy                   = busy_q;
    assign o_done                   = done_q;
    assign o_cs_n                   = cs_n_q;
    assign o_wr_n                   = wr_n_q;
    assign o_channel_address        = addr_q;
    assign o_mode                   = mode_q;
    assign o_data_upper_bits        = data_q[DATA_W-1 -: UPPER_W];
    assign o_data_lower_bits        = data_q[LOWER_W-1:0];
    assign o_output_update_strobe_n = ld_n_q;
    assign o_async_output_clear_n   = clr_n_q;
    assign o_power_down_n           = pd_n_q;

    // write strobe only ever low inside chip select
    chk_wr_in_cs: assert property (@(posedge i_clk) disable iff (i_rst)
        !wr_n_q |-> !cs_n_q) else $error("write strobe low without chip select");
    // strobe width is exactly the strobe count
    chk_wr_width: assert property (@(posedge i_clk) disable iff (i_rst)
        $fell(wr_n_q) |-> !wr_n_q [*2] ##1 wr_n_q) else $error("write strobe width wrong");
    // lines stay stable across rising write edge
    chk_data_stable: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(wr_n_q) |-> $stable(data_q) && $stable(addr_q) && $stable(mode_q))
        else $error("lines moved at write edge");
    // auto update keeps update strobe low over the rising write edge
    chk_auto_upd: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(wr_n_q) && !cs_n_q && $past(ld_n_q, 3) == 1'b0 |-> !ld_n_q)
        else $error("auto update dropped");
    // a standalone update pulse never overlaps a write
    chk_upd_alone: assert property (@(posedge i_clk) disable iff (i_rst)
        st_q == ST_UPDATE |-> cs_n_q && wr_n_q) else $error("update overlaps write");
    // clear pin follows request one cycle later
    chk_clear_pin: assert property (@(posedge i_clk) disable iff (i_rst)
        i_clear |=> !o_async_output_clear_n) else $error("clear not driven");
    // sleep pin follows request one cycle later
    chk_sleep_pin: assert property (@(posedge i_clk) disable iff (i_rst)
        i_sleep |=> !o_power_down_n) else $error("power down not driven");
    // a write completes with done within bounded time
    chk_write_done: assert property (@(posedge i_clk) disable iff (i_rst)
        st_q == ST_IDLE && i_req && !i_update |=> ##[1:8] done_q) else $error("write never finished");
    // mode line carries the class chosen at request
    chk_mode_class: assert property (@(posedge i_clk) disable iff (i_rst)
        st_q == ST_IDLE && i_req && !i_update |=> mode_q == $past(i_class)) else $error("mode mismatch");
    // a standalone update pulse lasts exactly the strobe count
    chk_upd_width: assert property (@(posedge i_clk) disable iff (i_rst)
        $fell(ld_n_q) && st_q == ST_UPDATE |-> !ld_n_q [*2] ##1 ld_n_q) else $error("update pulse width wrong");
    // chip select and write strobe are both released when a sequence ends
    chk_cs_release: assert property (@(posedge i_clk) disable iff (i_rst)
        done_q |-> cs_n_q && wr_n_q) else $error("chip select held after done");
    // system control writes put the parked address on the pins
    chk_sys_addr: assert property (@(posedge i_clk) disable iff (i_rst)
        st_q == ST_IDLE && i_req && !i_update && i_sys && i_class == CLASS_CTRL |=> addr_q == '0)
        else $error("system write address not parked");
endmodule

//--- testbench/dac_dev_model.sv
// behavioural parallel dac device answering the host controller pins
module dac_dev_model
    import dac_host_pkg::*;
#(
    parameter logic [DATA_W-1:0] CLR_CODE = 10'h200 // code that stands for the bias level
)(
    input  wire logic                 i_cs_n,
    input  wire logic                 i_wr_n,
    input  wire logic [ADDR_W-1:0]    i_addr,
    input  wire logic                 i_mode,
    input  wire logic [UPPER_W-1:0]   i_upper,
    input  wire logic [LOWER_W-1:0]   i_lower,
    input  wire logic                 i_update_n,
    input  wire logic                 i_clear_n,
    input  wire logic                 i_power_down_n,
    output logic [14:0]               o_last,
    output logic                      o_seen,
    output logic                      o_asleep,
    output logic [7:0][DATA_W-1:0]    o_main
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0][DATA_W-1:0] data_q = '0;
    logic [7:0][DATA_W-1:0] sub_q  = '0;
    wire  [DATA_W-1:0]      word   = {i_upper, i_lower};
    initial o_main = '0;
    initial o_seen = 1'b0;
    // capture on the rising strobe; no clock of its own, so edges are events here
    always @(posedge i_wr_n) begin
        if (!i_cs_n) begin
            o_last <= {i_update_n, i_mode, i_addr, word};
            o_seen <= ~o_seen;
            if (i_mode) begin
                data_q[i_addr] <= word;
                if (!i_update_n && i_clear_n) o_main[i_addr] <= word;
            end
        end // control class: channel address unused for the system register
    end
    // a falling update strobe copies every data register at once
    always @(negedge i_update_n) if (i_clear_n) o_main <= data_q;
    // clear wins over everything and recentres the sub dacs
    always @(negedge i_clear_n) begin
        o_main <= {8{CLR_CODE}};
        sub_q  <= '0;
    end
    assign o_asleep = !i_power_down_n;
endmodule

//--- testbench/parallel_dac_write_port_tb.sv
// self-checking bench for the dac host controller against the device model
module parallel_dac_write_port_tb
    import dac_host_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic i_clk = 0, i_rst = 1, i_req = 0, i_class = 0, i_sys = 0, i_auto = 0, i_update = 0, i_clear = 0, i_sleep = 0;
    logic [ADDR_W-1:0] i_addr = '0;
    logic [DATA_W-1:0] i_data = '0;
    logic busy, done, cs_n, wr_n, mode, upd_n, clr_n, pd_n, seen, asleep;
    logic [ADDR_W-1:0] ca;
    logic [UPPER_W-1:0] ub;
    logic [LOWER_W-1:0] lb;
    logic [14:0] last;
    logic [7:0][DATA_W-1:0] main, exp_data = '0, exp_main = '0;
    logic [14:0] exp_q[$];
    int n_mismatch = 0, n_checks = 0, cyc = 0;
    dac_write_host i_dac_write_host (.i_clk(i_clk), .i_rst(i_rst), .i_req(i_req), .i_addr(i_addr),
        .i_class(i_class), .i_sys(i_sys), .i_data(i_data), .i_auto(i_auto), .i_update(i_update),
        .i_clear(i_clear), .i_sleep(i_sleep), .o_busy(busy), .o_done(done), .o_cs_n(cs_n), .o_wr_n(wr_n),
        .o_channel_address(ca), .o_mode(mode), .o_data_upper_bits(ub), .o_data_lower_bits(lb),
        .o_output_update_strobe_n(upd_n), .o_async_output_clear_n(clr_n), .o_power_down_n(pd_n));
    dac_dev_model i_dac_dev_model (.i_cs_n(cs_n), .i_wr_n(wr_n), .i_addr(ca), .i_mode(mode), .i_upper(ub),
        .i_lower(lb), .i_update_n(upd_n), .i_clear_n(clr_n), .i_power_down_n(pd_n), .o_last(last),
        .o_seen(seen), .o_asleep(asleep), .o_main(main));
    always #25 i_clk = ~i_clk;
    task automatic chk(input string what, input logic [14:0] exp, input logic [14:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // bounded wait for the done pulse, then every main output is compared
    task automatic finish_op(input int exp_n);
        int n = 0;
        do begin
            @(posedge i_clk);
            #1;
            n++;
            if (n == 1) chk("busy", 15'h1, {14'h0, busy});
        end while (done !== 1'b1 && n < 20);
        chk("done", 15'h1, {14'h0, done});
        chk("latency", 15'(exp_n), 15'(n));
        for (int ch = 0; ch < 8; ch++) chk("main", {5'h00, exp_main[ch]}, {5'h00, main[ch]});
    endtask
    task automatic wr(input logic [2:0] a, input logic c, input logic s, input logic [9:0] d, input logic au);
        @(posedge i_clk);
        {i_req, i_addr, i_class, i_sys, i_data, i_auto} <= {1'b1, a, c, s, d, au};
        @(posedge i_clk);
        i_req <= 1'b0;
        exp_q.push_back({~au, c, (!c && s) ? 3'h0 : a, d});
        if (c) exp_data[a] = d;
        if (au) exp_main = exp_data;
        finish_op(SETUP_CYC + STROBE_CYC + HOLD_CYC);
    endtask
    // pairs each write the device took with the oldest one expected
    always @(seen iff !i_rst) begin
        #1;
        if (exp_q.size() == 0) chk("extra write", 15'h0, 15'h7FFF);
        else chk("capture", exp_q.pop_front(), last);
    end
    // a hang is cut short well past the longest sequence
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            end_of_test();
        end
    end
    initial begin
        void'($urandom(67026));
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        for (int ch = 0; ch < 8; ch++) wr(3'(ch), CLASS_DATA, 1'b0, 10'(ch * 97 + 1), 1'b0);
        @(posedge i_clk);
        i_update <= 1'b1;
        @(posedge i_clk);
        i_update <= 1'b0;
        exp_main = exp_data;
        finish_op(STROBE_CYC);
        // update and write asked together: the update wins and the write is dropped
        @(posedge i_clk);
        {i_update, i_req} <= 2'h3;
        @(posedge i_clk);
        {i_update, i_req} <= 2'h0;
        finish_op(STROBE_CYC);
        wr(3'h5, CLASS_CTRL, 1'b1, 10'h3FF, 1'b0);
        wr(3'h2, CLASS_CTRL, 1'b0, 10'h155, 1'b1);
        repeat (20) wr(3'($urandom), 1'($urandom), 1'($urandom), 10'($urandom), 1'($urandom));
        @(posedge i_clk);
        {i_clear, i_sleep} <= 2'h3;
        repeat (2) @(posedge i_clk);
        #1;
        for (int ch = 0; ch < 8; ch++) chk("cleared", 15'h200, {5'h00, main[ch]});
        chk("asleep", 15'h1, {14'h0, asleep});
        @(posedge i_clk);
        {i_clear, i_sleep} <= 2'h0;
        wr(3'h7, CLASS_DATA, 1'b0, 10'h2AA, 1'b1);
        chk("pending", 15'h0, 15'(exp_q.size()));
        chk("awake", 15'h0, {14'h0, asleep});
        end_of_test();
    end
endmodule
